// File: bench/mac_frame_statistics_counters_tb_top.sv
// Self-checking bench for the frame statistics counters, with a reference model.
// Assumes the bench drives every port on the falling edge of a single 10 MHz clock.
`timescale 1ns/100ps
module mac_frame_statistics_counters_tb_top
  import mac_stats_pkg::*;
;
  // ==========================================================
  // Stimulus and model state
  localparam rx_status_t PAT_S [NUM_CNT] = '{8'he0, 8'hc0, 8'h00};
  localparam logic PAT_T [NUM_CNT] = '{1'b0, 1'b0, 1'b1};
  localparam int LIM [NUM_CNT] = '{257, 4097, 65537};
  logic ref_clk_i = 1'b0;
  logic rst_n_i;
  logic en;
  rx_status_t st;
  logic tx;
  host_rd_t hr;
  logic [CNT_W-1:0] rd_data_o;
  logic rd_valid_o;
  logic flag_o;
  logic [CNT_W-1:0] m [NUM_CNT];
  int fail_count = 0;
  int n_compared = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  mac_frame_statistics_counters u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .counting_enable_i(en), .rx_status_i(st), .tx_ok_i(tx), .host_rd_i(hr),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .stats_threshold_flag_o(flag_o));

  // ==========================================================
  // Checking helpers
  task automatic check(input string what, input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [CNT_W-1:0] nxt(input logic [CNT_W-1:0] cur, input logic [CNT_W-1:0] max,
    input logic inc, input logic clr);
    if (clr) return inc ? CNT_ONE : CNT_RESET;
    if (!inc) return cur;
    return (cur == max) ? CNT_RESET : cur + CNT_ONE;
  endfunction

  // One cycle: drive at the falling edge, compare at the next falling edge
  task automatic step(input rx_status_t s, input logic t, input host_rd_t h);
    logic [NUM_CNT-1:0] inc;
    logic [CNT_W-1:0] nv;
    logic [CNT_W-1:0] e_data;
    logic e_flag;
    logic hit;
    st = s;
    tx = t;
    hr = h;
    inc[IDX_LOST] = en & s.done & s.addr_match & s.overrun & ~s.full_at_start;
    inc[IDX_RX_GOOD] = en & s.done & s.addr_match & ~s.overrun & ~s.full_at_start & ~s.too_long
      & ~s.fcs_err & ~s.len_err & ~s.align_err;
    inc[IDX_TX_GOOD] = en & t;
    e_data = CNT_RESET;
    e_flag = 1'b0;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      hit = h.rd && (h.addr == CNT_OFS[i]);
      if (hit) e_data = m[i];
      nv = nxt(m[i], CNT_MAX[i], inc[i], hit);
      if (inc[i] && nv == STATS_THRESH) e_flag = 1'b1;
      m[i] = nv;
    end
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("rd_data_o", rd_data_o, e_data);
    check("rd_valid_o", {15'h0000, rd_valid_o}, {15'h0000, h.rd});
    check("stats_threshold_flag_o", {15'h0000, flag_o}, {15'h0000, e_flag});
  endtask

  task automatic rd_all();
    for (int i = 0; i < NUM_CNT; i++) step(8'h00, 1'b0, {1'b1, CNT_OFS[i]});
  endtask

  task automatic test_end(input string name);
    $display("test %s finished, mismatches so far %0d", name, fail_count);
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog, well beyond the roughly 73200 cycles of the tests
  initial
  begin
    #(100000 * 100);
    fail_count++;
    stop_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] a;
    rst_n_i = 1'b0;
    en = 1'b1;
    st = 8'h00;
    tx = 1'b0;
    hr = 9'h000;
    m = '{CNT_RESET, CNT_RESET, CNT_RESET};
    void'($urandom(32'h3de9));
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    rd_all();
    step(8'h00, 1'b0, {1'b1, 8'h73});
    test_end("reset_and_unmapped");
    en = 1'b0;
    for (int c = 0; c < NUM_CNT; c++) step(PAT_S[c], 1'b1, 9'h000);
    rd_all();
    en = 1'b1;
    test_end("enable_off");
    for (int i = 0; i < 256; i++) step(i[7:0], 1'b0, 9'h000);
    rd_all();
    test_end("qualification");
    for (int c = 0; c < NUM_CNT; c++)
    begin
      repeat (LIM[c]) step(PAT_S[c], PAT_T[c], 9'h000);
      rd_all();
    end
    test_end("threshold_and_wrap");
    for (int c = 0; c < NUM_CNT; c++)
    begin
      step(PAT_S[c], PAT_T[c], 9'h000);
      step(PAT_S[c], PAT_T[c], {1'b1, CNT_OFS[c]});
    end
    rd_all();
    test_end("read_with_event");
    repeat (3000)
    begin
      en = ($urandom % 4) != 0;
      a = ($urandom % 4 == 3) ? 8'($urandom) : CNT_OFS[$urandom % 3];
      step(8'($urandom), 1'($urandom), {1'($urandom), a});
    end
    rd_all();
    test_end("random");
    stop_test();
  end
endmodule

// File: rtl/mac_frame_statistics_counters.sv
// Three clear-on-read frame statistics counters with a shared threshold flag.
// Assumes frame strobes and host reads arrive on ref_clk_i from same-clock logic.
//
// Operation
// - Count address-matched frames lost to overrun
// - Skip frames dropped with FIFO full initially
// - Lost counter 8 bits, wraps after 0xFF
// - Lost counter reaching 0xC0 raises flag
// - Reading lost counter returns and clears it
// - Count only while counting enable is set
// - Count good received frames, errors excluded
// - Received-good counter wraps after 0xFFF
// - Received-good reaching 0xC0 raises flag
// - Reading received-good counter clears it
// - Count each successfully transmitted frame
// - Transmitted-good counter wraps after 0xFFFF
// - Transmitted-good reaching 0xC0 raises flag
// - Reading transmitted-good counter clears it
`timescale 1ns/100ps
module mac_frame_statistics_counters
  import mac_stats_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic counting_enable_i,
  input wire rx_status_t rx_status_i,
  input wire logic tx_ok_i,
  input wire host_rd_t host_rd_i,
  output logic [CNT_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic stats_threshold_flag_o
);

  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] next_count(
    input logic [CNT_W-1:0] cur,
    input logic [CNT_W-1:0] max,
    input logic inc,
    input logic clr
  );
    logic [CNT_W-1:0] res;
    res = cur;
    if (clr)
    begin
      res = inc ? CNT_ONE : CNT_RESET;
    end
    else if (inc)
    begin
      res = (cur == max) ? CNT_RESET : cur + CNT_ONE;
    end
    return res;
  endfunction

  // ==========================================================
  // Event qualification
  logic rx_errored;
  logic lost_evt;
  logic good_evt;
  logic [NUM_CNT-1:0] evt;
  logic [NUM_CNT-1:0] inc;
  logic [NUM_CNT-1:0] clr;
  logic [NUM_CNT-1:0] hit;
  logic [CNT_W-1:0] cnt_q [NUM_CNT];
  logic [CNT_W-1:0] cnt_d [NUM_CNT];
  logic [CNT_W-1:0] rd_data_d;
  logic flag_d;

  assign rx_errored = rx_status_i.too_long | rx_status_i.fcs_err |
                      rx_status_i.len_err | rx_status_i.align_err;
  // Overrun seen by host only; a frame refused at start never counts
  assign lost_evt = rx_status_i.done & rx_status_i.addr_match & rx_status_i.overrun &
                    ~rx_status_i.full_at_start;
  assign good_evt = rx_status_i.done & rx_status_i.addr_match & ~rx_errored &
                    ~rx_status_i.overrun & ~rx_status_i.full_at_start;
  assign evt[IDX_LOST] = lost_evt;
  assign evt[IDX_RX_GOOD] = good_evt;
  assign evt[IDX_TX_GOOD] = tx_ok_i;

  // ==========================================================
  // Counter bank
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++)
    begin : g_cnt
      assign inc[g] = evt[g] & counting_enable_i;
      assign clr[g] = host_rd_i.rd & (host_rd_i.addr == CNT_OFS[g]);
      // Wrap limit per counter, clear and count together leave one
      assign cnt_d[g] = next_count(cnt_q[g], CNT_MAX[g], inc[g], clr[g]);
      assign hit[g] = inc[g] & (cnt_d[g] == STATS_THRESH);

      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          cnt_q[g] <= CNT_RESET;
        else
          cnt_q[g] <= cnt_d[g];
      end
    end
  endgenerate

  // ==========================================================
  // Host read port
  always_comb
  begin
    rd_data_d = CNT_RESET;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      if (clr[i])
        rd_data_d = cnt_q[i];
    end
  end

  assign flag_d = |hit;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= CNT_RESET;
      rd_valid_o <= 1'b0;
      stats_threshold_flag_o <= 1'b0;
    end
    else
    begin
      rd_data_o <= rd_data_d;
      rd_valid_o <= host_rd_i.rd;
      stats_threshold_flag_o <= flag_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_lost_read;
    clr[IDX_LOST] && !inc[IDX_LOST];
  endsequence

  sequence seq_lost_cleared;
    cnt_q[IDX_LOST] == CNT_RESET && rd_valid_o;
  endsequence

  chk_lost_counts: assert property (
    lost_evt && counting_enable_i && !clr[IDX_LOST] && cnt_q[IDX_LOST] != LOST_MAX
    |=> cnt_q[IDX_LOST] == $past(cnt_q[IDX_LOST]) + CNT_ONE)
    else $error("lost counter missed an overrun frame");

  chk_lost_full_start: assert property (
    rx_status_i.full_at_start && !clr[IDX_LOST] |=> $stable(cnt_q[IDX_LOST]))
    else $error("lost counter counted a frame refused at start");

  chk_lost_wrap: assert property (
    inc[IDX_LOST] && !clr[IDX_LOST] && cnt_q[IDX_LOST] == LOST_MAX
    |=> cnt_q[IDX_LOST] == CNT_RESET)
    else $error("lost counter did not wrap after 0xff");

  chk_lost_thresh: assert property (
    inc[IDX_LOST] && !clr[IDX_LOST] && cnt_q[IDX_LOST] == STATS_THRESH - CNT_ONE
    |=> stats_threshold_flag_o)
    else $error("lost counter at threshold raised no flag");

  chk_lost_read_clear: assert property (
    seq_lost_read |=> seq_lost_cleared ##0 rd_data_o == $past(cnt_q[IDX_LOST]))
    else $error("lost counter read did not return and clear");

  chk_enable_gate: assert property (
    !counting_enable_i && !host_rd_i.rd
    |=> $stable(cnt_q[IDX_LOST]) && $stable(cnt_q[IDX_RX_GOOD]) && $stable(cnt_q[IDX_TX_GOOD]))
    else $error("counter moved while counting disabled");

  chk_good_excludes: assert property (
    rx_status_i.done && (rx_errored || rx_status_i.overrun) && !clr[IDX_RX_GOOD]
    |=> $stable(cnt_q[IDX_RX_GOOD]))
    else $error("received-good counted a bad frame");

  chk_good_wrap: assert property (
    inc[IDX_RX_GOOD] && !clr[IDX_RX_GOOD] && cnt_q[IDX_RX_GOOD] == RX_GOOD_MAX
    |=> cnt_q[IDX_RX_GOOD] == CNT_RESET)
    else $error("received-good did not wrap after 0xfff");

  chk_good_thresh: assert property (
    inc[IDX_RX_GOOD] && !clr[IDX_RX_GOOD] && cnt_q[IDX_RX_GOOD] == STATS_THRESH - CNT_ONE
    |=> stats_threshold_flag_o ##1 (!stats_threshold_flag_o || $past(hit) != '0))
    else $error("received-good threshold flag wrong");

  chk_good_read_clear: assert property (
    clr[IDX_RX_GOOD] && !inc[IDX_RX_GOOD] |=> cnt_q[IDX_RX_GOOD] == CNT_RESET)
    else $error("received-good read did not clear");

  chk_tx_counts: assert property (
    inc[IDX_TX_GOOD] && !clr[IDX_TX_GOOD] && cnt_q[IDX_TX_GOOD] != TX_GOOD_MAX
    |=> cnt_q[IDX_TX_GOOD] == $past(cnt_q[IDX_TX_GOOD]) + CNT_ONE)
    else $error("transmitted-good missed a frame");

  chk_tx_wrap: assert property (
    inc[IDX_TX_GOOD] && !clr[IDX_TX_GOOD] && cnt_q[IDX_TX_GOOD] == TX_GOOD_MAX
    |=> cnt_q[IDX_TX_GOOD] == CNT_RESET)
    else $error("transmitted-good did not wrap after 0xffff");

  chk_tx_thresh: assert property (
    inc[IDX_TX_GOOD] && !clr[IDX_TX_GOOD] && cnt_q[IDX_TX_GOOD] == STATS_THRESH - CNT_ONE
    |=> stats_threshold_flag_o)
    else $error("transmitted-good threshold raised no flag");

  chk_tx_read_clear: assert property (
    clr[IDX_TX_GOOD] && !inc[IDX_TX_GOOD]
    |=> cnt_q[IDX_TX_GOOD] == CNT_RESET && rd_data_o == $past(cnt_q[IDX_TX_GOOD]))
    else $error("transmitted-good read did not return and clear");

  chk_read_race: assert property (
    clr[IDX_TX_GOOD] && inc[IDX_TX_GOOD] |=> cnt_q[IDX_TX_GOOD] == CNT_ONE)
    else $error("event lost during clearing read");

  chk_lost_read_race: assert property (
    clr[IDX_LOST] && inc[IDX_LOST] |=> cnt_q[IDX_LOST] == CNT_ONE)
    else $error("lost event dropped during clearing read");

  chk_good_read_race: assert property (
    clr[IDX_RX_GOOD] && inc[IDX_RX_GOOD] |=> cnt_q[IDX_RX_GOOD] == CNT_ONE)
    else $error("received-good event dropped during clearing read");

  chk_good_read_data: assert property (
    clr[IDX_RX_GOOD] |=> rd_valid_o && rd_data_o == $past(cnt_q[IDX_RX_GOOD]))
    else $error("received-good read returned a wrong value");

endmodule

// File: shared/mac_stats_pkg.sv
// Constants and carriers for the frame statistics counters.
// Assumes one core clock shared by the MAC datapath and the host register port.
package mac_stats_pkg;

  // ==========================================================
  // Register offsets from the I/O window base
  localparam logic [7:0] RX_GOOD_OFS = 8'h72;
  localparam logic [7:0] TX_GOOD_OFS = 8'h76;
  localparam logic [7:0] LOST_OFS = 8'h79;

  // ==========================================================
  // Counter bank layout
  localparam int NUM_CNT = 3;
  localparam int CNT_W = 16;
  localparam int IDX_LOST = 0;
  localparam int IDX_RX_GOOD = 1;
  localparam int IDX_TX_GOOD = 2;

  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] LOST_MAX = 16'h00ff;
  localparam logic [CNT_W-1:0] RX_GOOD_MAX = 16'h0fff;
  localparam logic [CNT_W-1:0] TX_GOOD_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] STATS_THRESH = 16'h00c0;

  localparam logic [7:0] CNT_OFS [NUM_CNT] = '{LOST_OFS, RX_GOOD_OFS, TX_GOOD_OFS};
  localparam logic [CNT_W-1:0] CNT_MAX [NUM_CNT] = '{LOST_MAX, RX_GOOD_MAX, TX_GOOD_MAX};

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic done;
    logic addr_match;
    logic overrun;
    logic full_at_start;
    logic too_long;
    logic fcs_err;
    logic len_err;
    logic align_err;
  } rx_status_t;

  typedef struct packed {
    logic rd;
    logic [7:0] addr;
  } host_rd_t;

endpackage
